// ===== hdl/pbm_stage.sv
// Pixel balance and matrix stage: register file on Avalon-MM, green
// imbalance thresholds, white balance with an output FIFO, colour matrix.
// Assumes single-clock neighbours on both pixel streams and a bus master
// that holds its request until waitrequest is seen low.
`timescale 1ns/1ps
`default_nettype none
`include "pbm_consts.svh"

// First-word FIFO with registered room flag
module pbm_fifo #(
  parameter int W = 14,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in,
  output logic [AW:0] count_out
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic room;
  } pbm_fifo_state_t;

  pbm_fifo_state_t st;
  pbm_fifo_state_t nx;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign push = ce_in && in_valid_in && st.room;
  assign pop = ce_in && out_ready_in && (st.cnt != '0);
  assign in_ready_out = st.room;
  assign out_valid_out = (st.cnt != '0);
  assign out_data_out = st.mem[st.rp];
  assign count_out = st.cnt;

  // Pointers, level and the room flag
  always_comb begin
    nx = st;
    if (push) begin
      nx.mem[st.wp] = in_data_in;
      nx.wp = st.wp + 1'b1;
    end
    if (pop) begin
      nx.rp = st.rp + 1'b1;
    end
    nx.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Registered so the filling side sees a clean flop
    nx.room = (nx.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '{mem: '0, wp: '0, rp: '0, cnt: '0, room: 1'b1};
    end else begin
      st <= nx;
    end
  end

  // Depth is a power of two so pointers wrap by themselves
  property p_fifo_level;
    @(posedge clk_in) disable iff (!rst_n_in)
      st.cnt <= (AW+1)'(DEPTH) && (st.room == (st.cnt != (AW+1)'(DEPTH)));
  endproperty
  a_fifo_level: assert property (p_fifo_level)
    else $error("fifo level or room flag wrong");
endmodule

// Summary of operation
// - With the table source chosen, each table threshold is scaled by an 8-bit U3.5 gain.
// - With the register source chosen, the programmed 12-bit value is the first threshold.
// - With the register source chosen, thresholds two to four add the slope one to three times.
// - Each Bayer colour gets its own signed 12-bit offset, all cleared at reset.
// - Each Bayer colour is scaled by its own U4.9 gain that resets to unity, code 512.
// - Matrix coefficients are signed 12-bit values with eight fraction bits.
// - After reset the matrix holds unity in RR and GG and zero in GR, RB and RG.
// - The source select bit picks programmed thresholds at zero and table thresholds at one.
module pbm_stage #(
  parameter int FIFO_DEPTH = 8,
  parameter int FIFO_AW = 3
) (
  // Clock, reset and enable
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Avalon-MM register slave
  input wire pbm_pkg::pbm_avm_req_t avm_req_in,
  output logic [31:0] avm_readdata_out,
  output logic avm_waitrequest_out,
  // Green imbalance thresholds
  input wire logic [3:0][9:0] nf2_thr_in,
  output logic [3:0][11:0] green_fix_thresh_first_out,
  // Bayer pixels in
  input wire logic bayer_valid_in,
  input wire pbm_pkg::pbm_bayer_t bayer_in,
  output logic bayer_ready_out,
  // Bayer pixels out
  output logic bayer_valid_out,
  output pbm_pkg::pbm_bayer_t bayer_out,
  input wire logic bayer_ready_in,
  // RGB pixels in
  input wire logic rgb_valid_in,
  input wire pbm_pkg::pbm_rgb_t rgb_in,
  output logic rgb_ready_out,
  // RGB pixels out
  output logic rgb_valid_out,
  output pbm_pkg::pbm_rgb_t rgb_out,
  input wire logic rgb_ready_in
);
  import pbm_pkg::*;

  typedef struct packed {
    pbm_bus_state_t bus;
    logic [31:0] rdata;
    logic [7:0] nfgain;
    logic [11:0] thr1;
    logic [11:0] slope;
    logic sel;
    logic [3:0][11:0] offs;
    logic [3:0][12:0] gains;
    logic [4:0][11:0] coef;
    logic [3:0][11:0] thr;
    logic bv;
    pbm_bayer_t bo;
    logic mv;
    logic mrdy;
    pbm_rgb_t mo;
  } pbm_state_t;

  localparam pbm_state_t ST_RST = '{
    bus: PBM_BUS_WAIT,
    rdata: '0,
    nfgain: '0,
    thr1: '0,
    slope: '0,
    sel: 1'b0,
    offs: '0,
    gains: {4{`PBM_RST_WBG}},
    coef: {`PBM_RST_COEF_UNITY, `PBM_RST_ZERO12, `PBM_RST_ZERO12,
           `PBM_RST_ZERO12, `PBM_RST_COEF_UNITY},
    thr: '0,
    bv: 1'b0,
    bo: '0,
    mv: 1'b0,
    mrdy: 1'b1,
    mo: '0
  };

  pbm_state_t st;
  pbm_state_t nx;
  logic [4:0] idx;
  logic [31:0] rd_word;
  logic [11:0] thr_calc [4];
  logic [1:0] ci;
  logic signed [13:0] wb_sum;
  logic [12:0] wb_base;
  logic [25:0] wb_prod;
  logic [16:0] wb_shift;
  logic [11:0] wb_value;
  logic f_valid;
  logic f_ready;
  pbm_bayer_t f_data;
  logic [FIFO_AW:0] f_count;
  logic pop;
  logic rgb_take;
  logic signed [26:0] acc_r;
  logic signed [26:0] acc_g;

  // Matrix sum back to pixel range
  function automatic logic [11:0] pbm_clip(input logic signed [26:0] acc);
    logic signed [18:0] sh;
    sh = 19'(acc >>> `PBM_COEF_FRAC);
    if (sh < 0) begin
      return 12'h000;
    end else if (sh > 19'sh00fff) begin
      return `PBM_PIX_MAX;
    end
    return sh[11:0];
  endfunction

  assign idx = avm_req_in.address;

  // Outputs straight from state
  assign avm_readdata_out = st.rdata;
  assign avm_waitrequest_out = st.bus;
  assign green_fix_thresh_first_out = st.thr;
  assign bayer_valid_out = st.bv;
  assign bayer_out = st.bo;
  assign rgb_ready_out = st.mrdy;
  assign rgb_valid_out = st.mv;
  assign rgb_out = st.mo;

  // Per-threshold source choice, saturated to the 12-bit field
  for (genvar i = 0; i < 4; i++) begin : g_thr
    logic [17:0] nf_p;
    logic [12:0] nf_s;
    logic [13:0] rg_s;
    assign nf_p = nf2_thr_in[i] * st.nfgain;
    assign nf_s = 13'(nf_p >> `PBM_NFG_FRAC);
    assign rg_s = {2'b00, st.thr1} + 14'(14'(i) * {2'b00, st.slope});
    assign thr_calc[i] = st.sel ?
      (nf_s[12] ? `PBM_PIX_MAX : nf_s[11:0]) :
      ((|rg_s[13:12]) ? `PBM_PIX_MAX : rg_s[11:0]);
  end

  // White balance of the incoming Bayer pixel
  always_comb begin
    ci = bayer_in.colour;
    wb_sum = $signed({2'b00, bayer_in.value}) +
      $signed({{2{st.offs[ci][11]}}, st.offs[ci]});
    wb_base = wb_sum[13] ? 13'h0000 : wb_sum[12:0];
    wb_prod = wb_base * st.gains[ci];
    wb_shift = 17'(wb_prod >> `PBM_WBG_FRAC);
    wb_value = (|wb_shift[16:12]) ? `PBM_PIX_MAX : wb_shift[11:0];
  end

  always_comb begin
    acc_r = 27'($signed(st.coef[0]) * $signed({1'b0, rgb_in.r})) +
      27'($signed(st.coef[1]) * $signed({1'b0, rgb_in.g})) +
      27'($signed(st.coef[2]) * $signed({1'b0, rgb_in.b}));
    // Green lacks its blue term; the matrix has no coefficient for it
    acc_g = 27'($signed(st.coef[3]) * $signed({1'b0, rgb_in.r})) +
      27'($signed(st.coef[4]) * $signed({1'b0, rgb_in.g}));
  end

  // Read mux, reserved bits zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (idx == `PBM_IDX_NFGAIN) begin
      rd_word[7:0] = st.nfgain;
    end else if (idx == `PBM_IDX_THR1) begin
      rd_word[11:0] = st.thr1;
    end else if (idx == `PBM_IDX_SLOPE) begin
      rd_word[11:0] = st.slope;
    end else if (idx >= `PBM_IDX_OFS_R && idx <= `PBM_IDX_OFS_B) begin
      rd_word[11:0] = st.offs[2'(idx - `PBM_IDX_OFS_R)];
    end else if (idx >= `PBM_IDX_GAIN_R && idx <= `PBM_IDX_GAIN_B) begin
      rd_word[12:0] = st.gains[2'(idx - `PBM_IDX_GAIN_R)];
    end else if (idx >= `PBM_IDX_COEF_RR && idx <= `PBM_IDX_COEF_GG) begin
      rd_word[11:0] = st.coef[3'(idx - `PBM_IDX_COEF_RR)];
    end else if (idx == `PBM_IDX_CTRL) begin
      rd_word[`PBM_CTRL_SEL_BIT] = st.sel;
    end else if (idx == `PBM_IDX_STAT) begin
      rd_word[FIFO_AW:0] = f_count;
      rd_word[`PBM_STAT_BV_BIT] = st.bv;
      rd_word[`PBM_STAT_MV_BIT] = st.mv;
    end
  end

  // Drain FIFO into the output register when it is free or taken
  assign pop = ce_in && f_valid && (!st.bv || bayer_ready_in);
  assign rgb_take = rgb_valid_in && st.mrdy;

  pbm_fifo #(
    .W($bits(pbm_bayer_t)),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .in_valid_in(bayer_valid_in),
    .in_data_in({bayer_in.colour, wb_value}),
    .in_ready_out(f_ready),
    .out_valid_out(f_valid),
    .out_data_out(f_data),
    .out_ready_in(pop),
    .count_out(f_count)
  );
  assign bayer_ready_out = f_ready;

  // Next state: bus, registers, thresholds and both pixel stages
  always_comb begin
    nx = st;
    if (ce_in) begin
      case (st.bus)
        PBM_BUS_WAIT: begin
          // One wait cycle lets the read word settle in a flop
          if (avm_req_in.read || avm_req_in.write) begin
            nx.bus = PBM_BUS_ACK;
            nx.rdata = rd_word;
          end
        end
        PBM_BUS_ACK: begin
          nx.bus = PBM_BUS_WAIT;
          if (avm_req_in.write) begin
            if (idx == `PBM_IDX_NFGAIN) begin
              nx.nfgain = avm_req_in.writedata[7:0];
            end else if (idx == `PBM_IDX_THR1) begin
              nx.thr1 = avm_req_in.writedata[11:0];
            end else if (idx == `PBM_IDX_SLOPE) begin
              nx.slope = avm_req_in.writedata[11:0];
            end else if (idx >= `PBM_IDX_OFS_R && idx <= `PBM_IDX_OFS_B) begin
              nx.offs[2'(idx - `PBM_IDX_OFS_R)] = avm_req_in.writedata[11:0];
            end else if (idx >= `PBM_IDX_GAIN_R && idx <= `PBM_IDX_GAIN_B) begin
              nx.gains[2'(idx - `PBM_IDX_GAIN_R)] = avm_req_in.writedata[12:0];
            end else if (idx >= `PBM_IDX_COEF_RR && idx <= `PBM_IDX_COEF_GG) begin
              nx.coef[3'(idx - `PBM_IDX_COEF_RR)] = avm_req_in.writedata[11:0];
            end else if (idx == `PBM_IDX_CTRL) begin
              nx.sel = avm_req_in.writedata[`PBM_CTRL_SEL_BIT];
            end
          end
        end
        default: begin
          nx.bus = PBM_BUS_WAIT;
        end
      endcase
      for (int k = 0; k < 4; k++) begin
        nx.thr[k] = thr_calc[k];
      end
      // Bayer output register
      if (pop) begin
        nx.bv = 1'b1;
        nx.bo = f_data;
      end else if (bayer_ready_in) begin
        nx.bv = 1'b0;
      end
      // Matrix stage: half rate, traded for a ready that is a plain flop
      if (rgb_take) begin
        nx.mv = 1'b1;
        nx.mo.r = pbm_clip(acc_r);
        nx.mo.g = pbm_clip(acc_g);
        nx.mo.b = rgb_in.b;
      end else if (st.mv && rgb_ready_in) begin
        nx.mv = 1'b0;
      end
      nx.mrdy = !nx.mv;
    end
  end

  // State register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= ST_RST;
    end else begin
      st <= nx;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_bus_req;
    ce_in && st.bus == PBM_BUS_WAIT && (avm_req_in.read || avm_req_in.write);
  endsequence

  sequence s_bus_done;
    !avm_waitrequest_out ##1 avm_waitrequest_out;
  endsequence

  property p_bus_handshake;
    s_bus_req ##1 ce_in |-> s_bus_done;
  endproperty
  a_bus_handshake: assert property (p_bus_handshake)
    else $error("bus answer not one wait cycle");

  property p_nf_gain;
    ce_in && st.sel |=> green_fix_thresh_first_out[1] ==
      ((18'($past(nf2_thr_in[1])) * $past(st.nfgain)) >= 18'h20000 ? `PBM_PIX_MAX :
      12'((18'($past(nf2_thr_in[1])) * $past(st.nfgain)) >> `PBM_NFG_FRAC));
  endproperty
  a_nf_gain: assert property (p_nf_gain)
    else $error("table threshold gain wrong");

  property p_thr_first;
    ce_in && !st.sel |=> green_fix_thresh_first_out[0] == $past(st.thr1);
  endproperty
  a_thr_first: assert property (p_thr_first)
    else $error("first threshold not programmed value");

  property p_thr_slope;
    ce_in && !st.sel && ({2'b00, st.thr1} + 14'(3 * st.slope)) < 14'h1000
      |=> green_fix_thresh_first_out[3] == 12'($past(st.thr1) + 3 * $past(st.slope))
      && green_fix_thresh_first_out[2] == 12'($past(st.thr1) + 2 * $past(st.slope));
  endproperty
  a_thr_slope: assert property (p_thr_slope)
    else $error("slope thresholds wrong");

  property p_src_switch;
    ce_in && $changed(st.sel) |=> green_fix_thresh_first_out[0] == (!$past(st.sel) ? $past(st.thr1) :
      ((18'($past(nf2_thr_in[0])) * $past(st.nfgain)) >= 18'h20000 ? `PBM_PIX_MAX :
      12'((18'($past(nf2_thr_in[0])) * $past(st.nfgain)) >> `PBM_NFG_FRAC)));
  endproperty
  a_src_switch: assert property (p_src_switch)
    else $error("threshold source not followed");

  property p_reset_values;
    !$past(rst_n_in) |-> st.coef[0] == 12'h100 && st.coef[4] == 12'h100
      && st.coef[3:1] == '0 && st.offs == '0 && st.gains[2] == 13'h0200;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("coefficients wrong after reset");

  property p_wb_unity;
    st.offs[ci] == '0 && st.gains[ci] == 13'h0200 |-> wb_value == bayer_in.value;
  endproperty
  a_wb_unity: assert property (p_wb_unity)
    else $error("unity balance changes pixel");

  property p_wb_offset;
    st.gains[ci] == 13'h0200 && $signed(st.offs[ci]) < 0
      && bayer_in.value < 12'(-$signed(st.offs[ci])) |-> wb_value == 12'h000;
  endproperty
  a_wb_offset: assert property (p_wb_offset)
    else $error("negative offset not clamped");

  property p_mat_sign;
    rgb_take && ce_in && st.coef[0] == 12'hf00 && st.coef[2:1] == '0
      |=> rgb_valid_out && rgb_out.r == 12'h000;
  endproperty
  a_mat_sign: assert property (p_mat_sign)
    else $error("negative coefficient not signed");

  property p_wb_sat;
    wb_shift > 17'h00fff |-> wb_value == 12'hfff;
  endproperty
  a_wb_sat: assert property (p_wb_sat)
    else $error("balance result wrapped");
endmodule

`default_nettype wire

// ===== hdl/pbm_consts.svh
// Constants of the pixel balance and matrix stage: register word indices,
// field positions, fixed-point fraction widths and reset values.
// Assumes the register bus carries word addresses, one register per word.
`ifndef PBM_CONSTS_SVH
`define PBM_CONSTS_SVH

// Register word indices
`define PBM_IDX_NFGAIN 5'h00
`define PBM_IDX_THR1 5'h01
`define PBM_IDX_SLOPE 5'h02
`define PBM_IDX_OFS_R 5'h03
`define PBM_IDX_OFS_B 5'h06
`define PBM_IDX_GAIN_R 5'h07
`define PBM_IDX_GAIN_B 5'h0a
`define PBM_IDX_COEF_RR 5'h0b
`define PBM_IDX_COEF_GG 5'h0f
`define PBM_IDX_CTRL 5'h10
`define PBM_IDX_STAT 5'h11

// Field positions
`define PBM_CTRL_SEL_BIT 0
`define PBM_STAT_BV_BIT 4
`define PBM_STAT_MV_BIT 5

// Fraction bits of the fixed-point fields
`define PBM_NFG_FRAC 5
`define PBM_WBG_FRAC 9
`define PBM_COEF_FRAC 8

// Reset values and limits
`define PBM_RST_WBG 13'h0200
`define PBM_RST_COEF_UNITY 12'h100
`define PBM_RST_ZERO12 12'h000
`define PBM_PIX_MAX 12'hfff

`endif

// ===== hdl/pbm_pkg.sv
// Types of the pixel balance and matrix stage.
// Assumes 12-bit pixels on both pixel streams.
package pbm_pkg;

  // Bayer colour of a raw pixel
  typedef enum logic [1:0] {
    PBM_COL_R = 2'b00,
    PBM_COL_GR = 2'b01,
    PBM_COL_GB = 2'b10,
    PBM_COL_B = 2'b11
  } pbm_colour_t;

  // Register bus handshake state
  typedef enum logic {
    PBM_BUS_ACK = 1'b0,
    PBM_BUS_WAIT = 1'b1
  } pbm_bus_state_t;

  typedef struct packed {
    pbm_colour_t colour;
    logic [11:0] value;
  } pbm_bayer_t;

  typedef struct packed {
    logic [11:0] r;
    logic [11:0] g;
    logic [11:0] b;
  } pbm_rgb_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } pbm_avm_req_t;

endpackage

// ===== bench/pbm_sink_model.sv
// Downstream pixel sink: collects balanced Bayer and matrix RGB pixels.
// Assumes the stage clock; mode 0 always ready, 1 random stalls, 2 stalled.
`timescale 1ns/1ps
`default_nettype none
module pbm_sink_model (
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [1:0] mode_in,
  // Bayer side
  input wire logic bayer_valid_in,
  input wire pbm_pkg::pbm_bayer_t bayer_in,
  output logic bayer_ready_out,
  // RGB side
  input wire logic rgb_valid_in,
  input wire pbm_pkg::pbm_rgb_t rgb_in,
  output logic rgb_ready_out
);
  import pbm_pkg::*;
  pbm_bayer_t bq[$];
  pbm_rgb_t rq[$];
  // Ready redrawn every cycle, since a real stage may stall at any time
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bayer_ready_out <= 1'b0;
      rgb_ready_out <= 1'b0;
    end else if (ce_in) begin
      if (bayer_valid_in && bayer_ready_out) bq.push_back(bayer_in);
      if (rgb_valid_in && rgb_ready_out) rq.push_back(rgb_in);
      bayer_ready_out <= (mode_in == 2'd0) || (mode_in == 2'd1 && $urandom_range(1) == 1);
      rgb_ready_out <= (mode_in == 2'd0) || (mode_in == 2'd1 && $urandom_range(2) != 0);
    end
  end
endmodule
`default_nettype wire

// ===== bench/test_pixel_balance_matrix_stage.sv
// Self-checking bench of the pixel balance and matrix stage.
// Assumes the sink model downstream; the bench is bus master and upstream.
`timescale 1ns/1ps
`default_nettype none
module test_pixel_balance_matrix_stage;
  import pbm_pkg::*;
  logic clk, rst_n, ce, bvi, bro, bvo, bri, rvi, rro, rvo, rri, wreq;
  logic [1:0] mode;
  logic [31:0] rdata, q;
  logic [3:0][9:0] nf2;
  logic [3:0][11:0] thr;
  logic [11:0] t1, sl, ofs[4], cf[5];
  logic [12:0] gn[4];
  logic [7:0] g;
  pbm_avm_req_t req;
  pbm_bayer_t bi, bo, exp_b[$];
  pbm_rgb_t ri, ro, exp_r[$];
  int error_cnt, tests_run;
  int cyc = 0;

  pbm_stage #(.FIFO_DEPTH(8), .FIFO_AW(3)) uut (
    .core_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .avm_req_in(req),
    .avm_readdata_out(rdata), .avm_waitrequest_out(wreq), .nf2_thr_in(nf2),
    .green_fix_thresh_first_out(thr), .bayer_valid_in(bvi), .bayer_in(bi), .bayer_ready_out(bro),
    .bayer_valid_out(bvo), .bayer_out(bo), .bayer_ready_in(bri), .rgb_valid_in(rvi),
    .rgb_in(ri), .rgb_ready_out(rro), .rgb_valid_out(rvo), .rgb_out(ro),
    .rgb_ready_in(rri));
  pbm_sink_model sink (
    .clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .mode_in(mode),
    .bayer_valid_in(bvo), .bayer_in(bo), .bayer_ready_out(bri),
    .rgb_valid_in(rvo), .rgb_in(ro), .rgb_ready_out(rri));

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    req <= '{read: !wr, write: wr, address: a, writedata: d};
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    req <= '0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] msk(input int i);
    msk = (i == 0) ? 32'hff : (i >= 7 && i <= 10) ? 32'h1fff : 32'hfff;
    if (i >= 16) msk = (i == 16) ? 32'h1 : 32'h0;
  endfunction

  function automatic logic [31:0] rv(input int i);
    rv = (i >= 7 && i <= 10) ? 32'h200 : (i == 11 || i == 15) ? 32'h100 : 32'h0;
  endfunction

  function automatic int sx(input logic [11:0] c);
    sx = int'($signed(c));
  endfunction

  function automatic logic [11:0] clip(input int x);
    clip = (x < 0) ? 12'h000 : (x > 4095) ? 12'hfff : x[11:0];
  endfunction

  function automatic logic [11:0] tex(input int k, input logic sel);
    tex = sel ? clip(int'(nf2[k]) * int'(g) >>> 5) : clip(int'(t1) + k * int'(sl));
  endfunction

  function automatic logic [11:0] bal(input logic [11:0] v, input pbm_colour_t c);
    int s;
    s = int'(v) + sx(ofs[c]);
    bal = clip((s < 0 ? 0 : s) * int'(gn[c]) >>> 9);
  endfunction

  function automatic pbm_rgb_t mat(input pbm_rgb_t p);
    mat.r = clip((sx(cf[0]) * int'(p.r) + sx(cf[1]) * int'(p.g) + sx(cf[2]) * int'(p.b)) >>> 8);
    mat.g = clip((sx(cf[3]) * int'(p.r) + sx(cf[4]) * int'(p.g)) >>> 8);
    mat.b = p.b;
  endfunction

  // Bayer source; with fill it stops at the first refused cycle
  task automatic push_b(input int n, input bit fill);
    pbm_bayer_t p;
    for (int i = 0; i < n; i++) begin
      p = pbm_bayer_t'(14'($urandom));
      if (i < 2) p.value = i ? 12'h000 : 12'hfff;
      bvi <= 1'b1;
      bi <= p;
      do @(posedge clk); while (bro !== 1'b1 && !fill);
      if (bro !== 1'b1) break;
      exp_b.push_back('{p.colour, bal(p.value, p.colour)});
    end
    bvi <= 1'b0;
  endtask

  task automatic push_r(input int n);
    pbm_rgb_t p;
    for (int i = 0; i < n; i++) begin
      p = pbm_rgb_t'({$urandom, 4'h0});
      if (i == 0) p = '1;
      rvi <= 1'b1;
      ri <= p;
      do @(posedge clk); while (rro !== 1'b1);
      exp_r.push_back(mat(p));
    end
    rvi <= 1'b0;
  endtask

  // Let the sink take everything, then compare in order
  task automatic drain();
    mode <= 2'd1;
    for (int w = 0; w < 500; w++) begin
      if (sink.bq.size() >= exp_b.size() && sink.rq.size() >= exp_r.size()) break;
      @(posedge clk);
    end
    chk("bayer count", 36'(sink.bq.size()), 36'(exp_b.size()));
    chk("rgb count", 36'(sink.rq.size()), 36'(exp_r.size()));
    foreach (exp_b[i]) chk("bayer pixel", sink.bq[i], exp_b[i]);
    foreach (exp_r[i]) chk("rgb pixel", sink.rq[i], exp_r[i]);
    sink.bq.delete();
    sink.rq.delete();
    exp_b.delete();
    exp_r.delete();
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h7074b555));
    rst_n = 1'b0;
    ce = 1'b1;
    req = '0;
    bvi = 1'b0;
    bi = '0;
    rvi = 1'b0;
    ri = '0;
    mode = 2'd0;
    nf2 = '0;
    error_cnt = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ofs = '{default: 12'h000};
    gn = '{default: 13'h0200};
    cf = '{12'h100, 12'h000, 12'h000, 12'h000, 12'h100};
    push_b(6, 1'b0);
    push_r(6);
    drain();
    // Reset values, field widths, read-only and unmapped words
    for (int i = 0; i < 19; i++) begin
      bus(1'b0, 5'(i), 32'h0);
      chk("reset value", q, rv(i));
      bus(1'b1, 5'(i), i >= 17 ? 32'h3f : msk(i));
      bus(1'b0, 5'(i), 32'h0);
      chk("read back", q, msk(i));
    end
    // Both threshold sources, alternating
    for (int k = 0; k < 6; k++) begin
      t1 = (k == 0) ? 12'hfff : 12'($urandom) >> k;
      sl = 12'($urandom) >> (k * 2);
      g = 8'($urandom);
      nf2 <= 40'({$urandom, $urandom});
      bus(1'b1, 5'h01, 32'(t1));
      bus(1'b1, 5'h02, 32'(sl));
      bus(1'b1, 5'h00, 32'(g));
      bus(1'b1, 5'h10, 32'(k % 2));
      repeat (2) @(posedge clk);
      for (int j = 0; j < 4; j++) chk("threshold", thr[j], tex(j, k[0]));
    end
    // Clock enable low freezes the thresholds
    q = 32'(tex(0, 1'b1));
    ce <= 1'b0;
    nf2 <= ~nf2;
    repeat (3) @(posedge clk);
    chk("frozen threshold", thr[0], q[11:0]);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    chk("resumed threshold", thr[0], tex(0, 1'b1));
    // Per-colour balance, most negative offset and unity gain on red
    for (int c = 0; c < 4; c++) begin
      ofs[c] = (c == 0) ? 12'h800 : 12'($urandom);
      gn[c] = (c == 0) ? 13'h0200 : 13'($urandom);
      bus(1'b1, 5'(3 + c), 32'(ofs[c]));
      bus(1'b1, 5'(7 + c), 32'(gn[c]));
    end
    mode <= 2'd2;
    push_b(20, 1'b1);
    bus(1'b0, 5'h11, 32'h0);
    chk("full status", q, 32'h18);
    chk("held valid", bvo, 1'b1);
    drain();
    push_b(60, 1'b0);
    drain();
    // Matrix with extreme then random coefficients
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 5; c++) begin
        cf[c] = (k == 0) ? ((c == 0) ? 12'h800 : 12'h7ff) : 12'($urandom);
        // Pure negative red term must clamp red to zero
        if (k == 1 && c < 3) cf[c] = (c == 0) ? 12'hf00 : 12'h000;
        bus(1'b1, 5'(11 + c), 32'(cf[c]));
      end
      push_r(8);
      drain();
    end
    finish_test();
  end
endmodule
`default_nettype wire
